// >>> rtl/sbpc_pointer.sv
// Sequential address pointer core
`timescale 1ns/1ps
`include "sbpc_params.svh"
module sbpc_pointer
    import sbpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic pointer_load_strobe_n,
    input wire logic jump_first_start_n,
    input wire logic jump_second_start_n,
    input wire logic count_advance_enable_n,
    input wire logic [11:0] load_addr,
    output logic [11:0] pointer,
    output logic halted,
    output logic load_phase,
    sbpc_cmd_if.core cif
);
    sbpc_state_e state;
    logic [11:0] load_hold;
    logic [1:0] flags;
    logic at1;
    logic at2;
    logic adv;
    assign at1 = pointer == cif.buffer_one_end;
    assign at2 = pointer == cif.buffer_two_end;
    assign cif.flags = flags;
    assign halted = state == SBPC_HALT;
    assign load_phase = state == SBPC_LOAD;
    // Advance actually taken this cycle
    assign adv = state == SBPC_RUN && pointer_load_strobe_n && jump_first_start_n
                 && jump_second_start_n && !count_advance_enable_n;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            load_hold <= `SBPC_RST_PTR;
        end else if (!pointer_load_strobe_n) begin
            load_hold <= load_addr;
        end
    end

    // Asynchronous reset of pointer and state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pointer <= `SBPC_RST_PTR;
            state <= SBPC_RUN;
        end else if (!pointer_load_strobe_n) begin
            state <= SBPC_LOAD;
        end else if (state == SBPC_LOAD) begin
            pointer <= load_hold;
            state <= SBPC_RUN;
        end else if (!jump_first_start_n) begin
            pointer <= cif.buffer_one_start;
            state <= SBPC_RUN;
        end else if (!jump_second_start_n) begin
            pointer <= cif.buffer_two_start;
            state <= SBPC_RUN;
        end else if (state == SBPC_HALT) begin
            if (cif.release_stb) begin
                state <= SBPC_RUN;
            end
        end else if (!count_advance_enable_n) begin
            if (at1 && cif.mode1 == `SBPC_MODE_STOP) begin
                state <= SBPC_HALT;
            end else if (at2 && cif.mode2 == `SBPC_MODE_STOP) begin
                state <= SBPC_HALT;
            end else if (at1) begin
                pointer <= cif.buffer_two_start;
            end else if (at2) begin
                pointer <= cif.buffer_one_start;
            end else begin
                pointer <= pointer + `SBPC_ONE;
            end
        end
    end

    // Sticky end flags, set beats clear
    // Set only on an advance at the end; reset defaults may match with no transfer
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags <= 2'h0;
        end else begin
            flags <= (flags & ~cif.flag_clr) | {adv && at2, adv && at1};
        end
    end

    // Load lands one cycle after capture
    property p_load;
        @(posedge core_clk) disable iff (rst)
        !pointer_load_strobe_n ##1 pointer_load_strobe_n |=> pointer == $past(load_hold);
    endproperty
    a_load: assert property (p_load) else $error("load not applied");
    property p_noinc;
        @(posedge core_clk) disable iff (rst)
        (!pointer_load_strobe_n && !load_phase) |=> $stable(pointer);
    endproperty
    a_noinc: assert property (p_noinc) else $error("pointer moved during load");
    property p_jump1;
        @(posedge core_clk) disable iff (rst)
        (pointer_load_strobe_n && !load_phase && !jump_first_start_n)
            |=> pointer == $past(cif.buffer_one_start);
    endproperty
    a_jump1: assert property (p_jump1) else $error("jump one failed");
    property p_jump2;
        @(posedge core_clk) disable iff (rst)
        (pointer_load_strobe_n && !load_phase && jump_first_start_n && !jump_second_start_n)
            |=> pointer == $past(cif.buffer_two_start);
    endproperty
    a_jump2: assert property (p_jump2) else $error("jump two failed");
    property p_halt;
        @(posedge core_clk) disable iff (rst)
        halted && pointer_load_strobe_n && jump_first_start_n && jump_second_start_n
            |=> $stable(pointer);
    endproperty
    a_halt: assert property (p_halt) else $error("halted pointer moved");
    property p_flag;
        @(posedge core_clk) disable iff (rst) adv && at1 |=> flags[0];
    endproperty
    a_flag: assert property (p_flag) else $error("end flag not set");
    property p_chain;
        @(posedge core_clk) disable iff (rst)
        (state == SBPC_RUN && pointer_load_strobe_n && jump_first_start_n
         && jump_second_start_n && !count_advance_enable_n && at1
         && cif.mode1 == `SBPC_MODE_CHAIN) |=> pointer == $past(cif.buffer_two_start);
    endproperty
    a_chain: assert property (p_chain) else $error("chain jump missing");
    property p_release;
        @(posedge core_clk) disable iff (rst)
        halted && cif.release_stb && pointer_load_strobe_n |=> !halted;
    endproperty
    a_release: assert property (p_release) else $error("halt not released");
    c_load: cover property (@(posedge core_clk) disable iff (rst) load_phase);
    c_halt: cover property (@(posedge core_clk) disable iff (rst) halted);
    c_chain: cover property (@(posedge core_clk) disable iff (rst) at1 && !count_advance_enable_n);
endmodule

// >>> pkg/sbpc_params.svh
// Constants for the sequential buffer pointer control block
`ifndef SBPC_PARAMS_SVH
`define SBPC_PARAMS_SVH
`define SBPC_AW 12
`define SBPC_DW 16
`define SBPC_CMD_BUFFER_ONE_START 3'h0
`define SBPC_CMD_BUFFER_ONE_END 3'h1
`define SBPC_CMD_BUFFER_TWO_START 3'h2
`define SBPC_CMD_BUFFER_TWO_END 3'h3
`define SBPC_CMD_FLOW 3'h4
`define SBPC_CMD_FLAG 3'h5
`define SBPC_RST_PTR 12'h000
`define SBPC_RST_BUFFER_ONE_START 12'h000
`define SBPC_RST_BUFFER_ONE_END 12'hfff
`define SBPC_RST_BUFFER_TWO_START 12'h000
`define SBPC_RST_BUFFER_TWO_END 12'h000
`define SBPC_HI_BITS 4'he
`define SBPC_ALL_ONES 16'hffff
`define SBPC_MODE_CHAIN 2'h0
`define SBPC_MODE_STOP 2'h1
`define SBPC_FLOW_REL_BIT 4
`define SBPC_ONE 12'h001
`endif

// >>> pkg/sbpc_pkg.sv
// Types for the sequential buffer pointer control block
package sbpc_pkg;
    typedef enum logic [2:0] {
        SBPC_RUN = 3'b001,
        SBPC_LOAD = 3'b010,
        SBPC_HALT = 3'b100
    } sbpc_state_e;
endpackage

// >>> pkg/sbpc_cmd_if.sv
// Command register bundle between host decoder and pointer core
`timescale 1ns/1ps
interface sbpc_cmd_if;
    logic [11:0] buffer_one_start;
    logic [11:0] buffer_one_end;
    logic [11:0] buffer_two_start;
    logic [11:0] buffer_two_end;
    logic [1:0] mode1;
    logic [1:0] mode2;
    logic release_stb;
    logic [1:0] flag_clr;
    logic [1:0] flags;
    modport regs (output buffer_one_start, buffer_one_end, buffer_two_start, buffer_two_end, mode1, mode2, release_stb, flag_clr,
                  input flags);
    modport core (input buffer_one_start, buffer_one_end, buffer_two_start, buffer_two_end, mode1, mode2, release_stb, flag_clr,
                  output flags);
endinterface

// >>> rtl/sbpc_cmd_regs.sv
// Host command mode register file
`timescale 1ns/1ps
`include "sbpc_params.svh"
module sbpc_cmd_regs
    import sbpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cmd_select_n,
    input wire logic chip_select_n,
    input wire logic host_read_not_write,
    input wire logic [2:0] host_addr,
    input wire logic [15:0] host_wdata,
    output logic [15:0] host_rdata,
    sbpc_cmd_if.regs cif
);
    logic sel;
    logic wr;
    logic [4:0] flow;
    assign sel = !cmd_select_n && chip_select_n;
    assign wr = sel && !host_read_not_write;
    assign cif.mode1 = flow[1:0];
    assign cif.mode2 = flow[3:2];
    // Only low address and data bits used
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cif.buffer_one_start <= `SBPC_RST_BUFFER_ONE_START;
            cif.buffer_one_end <= `SBPC_RST_BUFFER_ONE_END;
            cif.buffer_two_start <= `SBPC_RST_BUFFER_TWO_START;
            cif.buffer_two_end <= `SBPC_RST_BUFFER_TWO_END;
            flow <= 5'h00;
        end else if (wr) begin
            case (host_addr)
                `SBPC_CMD_BUFFER_ONE_START: cif.buffer_one_start <= host_wdata[11:0];
                `SBPC_CMD_BUFFER_ONE_END: cif.buffer_one_end <= host_wdata[11:0];
                `SBPC_CMD_BUFFER_TWO_START: cif.buffer_two_start <= host_wdata[11:0];
                `SBPC_CMD_BUFFER_TWO_END: cif.buffer_two_end <= host_wdata[11:0];
                `SBPC_CMD_FLOW: flow <= host_wdata[4:0];
                default: ;
            endcase
        end
    end
    // Zero in bit 4 releases a halt
    assign cif.release_stb = wr && host_addr == `SBPC_CMD_FLOW
                             && !host_wdata[`SBPC_FLOW_REL_BIT];
    // Zero bits clear flags, ones keep
    assign cif.flag_clr = (wr && host_addr == `SBPC_CMD_FLAG) ? ~host_wdata[1:0] : 2'h0;
    // Read data with high bits set
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            host_rdata <= `SBPC_ALL_ONES;
        end else begin
            case (host_addr)
                `SBPC_CMD_BUFFER_ONE_START: host_rdata <= {`SBPC_HI_BITS, cif.buffer_one_start};
                `SBPC_CMD_BUFFER_ONE_END: host_rdata <= {`SBPC_HI_BITS, cif.buffer_one_end};
                `SBPC_CMD_BUFFER_TWO_START: host_rdata <= {`SBPC_HI_BITS, cif.buffer_two_start};
                `SBPC_CMD_BUFFER_TWO_END: host_rdata <= {`SBPC_HI_BITS, cif.buffer_two_end};
                `SBPC_CMD_FLOW: host_rdata <= {11'h7ff, flow};
                `SBPC_CMD_FLAG: host_rdata <= {14'h3fff, cif.flags};
                default: host_rdata <= `SBPC_ALL_ONES;
            endcase
        end
    end
    c_cmd_write: cover property (@(posedge core_clk) disable iff (rst) wr);
endmodule

// >>> rtl/sbpc_top.sv
// Summary of operation
// - Load strobe low captures data bits 11..0 into a hold register.
// - Pointer takes the held address one cycle after capture.
// - Count enable ignored during load cycle and the next one.
// - Jump strobe moves pointer to stored start address in one cycle.
// - Jump data ready one edge later; load data two edges later.
// - Load address taken from bits 11..0 only.
// - Reset acts at once, without the clock.
// - Reset gives pointer 0, flags clear, chaining, first buffer 0..4095.
// - Command mode decodes address 2..0 and data 11..0 only.
// - Codes 000..100 select start/end registers and flow control.
// - Code 101 clears or reads flags; 110/111 are illegal.
// - Start/end registers hold 12 bits; reads show bits 15..13 high.
// - Command access: write when read-write low, selected by command select low with chip select high.
// - Each buffer has its own mode, chaining or stop.
// - Chaining: at end, set flag, continue at other buffer start.
// - Stop: pointer halts at buffer end.
// - Flow bits 1..0 buffer one, 3..2 buffer two; 00 chain, 01 stop.
// - Zero in flow bit 4 releases a stop halt.
// - Writing zero to flag bit clears that flag; one keeps it.
// - End outputs go low one cycle after an advance at the buffer end sets its flag.
`timescale 1ns/1ps
`include "sbpc_params.svh"
module sbpc_top
    import sbpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic pointer_load_strobe_n,
    input wire logic jump_first_start_n,
    input wire logic jump_second_start_n,
    input wire logic count_advance_enable_n,
    input wire logic seq_port_select_n,
    input wire logic seq_read_not_write,
    input wire logic [15:0] seq_data_in,
    input wire logic cmd_select_n,
    input wire logic chip_select_n,
    input wire logic host_read_not_write,
    input wire logic [11:0] host_addr,
    input wire logic [15:0] host_wdata,
    output logic [15:0] host_rdata,
    output logic [11:0] seq_pointer,
    output logic seq_write_allowed,
    output logic seq_select_reg_n,
    output logic seq_rnw_reg,
    output logic first_end_flag_n,
    output logic second_end_flag_n
);
    sbpc_cmd_if cif();
    logic halted;
    logic load_phase;

    // ------------------------------------------------------------
    // Command registers
    // ------------------------------------------------------------
    sbpc_cmd_regs u_regs (
        .core_clk(core_clk),
        .rst(rst),
        .cmd_select_n(cmd_select_n),
        .chip_select_n(chip_select_n),
        .host_read_not_write(host_read_not_write),
        .host_addr(host_addr[2:0]),
        .host_wdata(host_wdata),
        .host_rdata(host_rdata),
        .cif(cif)
    );

    // ------------------------------------------------------------
    // Pointer core
    // ------------------------------------------------------------
    // Only low twelve data lines address
    sbpc_pointer u_ptr (
        .core_clk(core_clk),
        .rst(rst),
        .pointer_load_strobe_n(pointer_load_strobe_n),
        .jump_first_start_n(jump_first_start_n),
        .jump_second_start_n(jump_second_start_n),
        .count_advance_enable_n(count_advance_enable_n),
        .load_addr(seq_data_in[11:0]),
        .pointer(seq_pointer),
        .halted(halted),
        .load_phase(load_phase),
        .cif(cif)
    );

    // ------------------------------------------------------------
    // Sequential status
    // ------------------------------------------------------------
    // End outputs active low, registered from sticky end flags
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            first_end_flag_n <= 1'b1;
            second_end_flag_n <= 1'b1;
        end else begin
            first_end_flag_n <= !cif.flags[0] || cif.flag_clr[0];
            second_end_flag_n <= !cif.flags[1] || cif.flag_clr[1];
        end
    end
    // Registered select high, rnw low at reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            seq_select_reg_n <= 1'b1;
            seq_rnw_reg <= 1'b0;
        end else begin
            seq_select_reg_n <= seq_port_select_n;
            seq_rnw_reg <= seq_read_not_write;
        end
    end
    // Data valid outside load phase and halt
    assign seq_write_allowed = !halted && !load_phase;
endmodule

// >>> tb/sbpc_seq_host_model.sv
// Partner model: sequential bus master and command-mode host
`timescale 1ns/1ps
module sbpc_seq_host_model (
    input wire logic core_clk,
    input wire logic [15:0] host_rdata,
    output logic pointer_load_strobe_n,
    output logic jump_first_start_n,
    output logic jump_second_start_n,
    output logic count_advance_enable_n,
    output logic seq_port_select_n,
    output logic seq_read_not_write,
    output logic [15:0] seq_data_in,
    output logic cmd_select_n,
    output logic chip_select_n,
    output logic host_read_not_write,
    output logic [11:0] host_addr,
    output logic [15:0] host_wdata
);
    logic [15:0] last_rd;
    // ------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------
    initial begin
        pointer_load_strobe_n = 1'b1;
        jump_first_start_n = 1'b1;
        jump_second_start_n = 1'b1;
        count_advance_enable_n = 1'b1;
        seq_port_select_n = 1'b1;
        seq_read_not_write = 1'b1;
        seq_data_in = 16'h5a5a;
        cmd_select_n = 1'b1;
        chip_select_n = 1'b1;
        host_read_not_write = 1'b1;
        host_addr = 12'ha5a;
        host_wdata = 16'ha5a5;
        last_rd = 16'h0000;
    end
    // ------------------------------------------------------------
    // Host and sequential tasks
    // ------------------------------------------------------------
    // only while sequential port idle
    task automatic host_cycle(input logic rnw, input logic cs_n, input logic [11:0] a,
                              input logic [15:0] d);
        @(negedge core_clk);
        cmd_select_n = 1'b0;
        chip_select_n = cs_n;
        host_read_not_write = rnw;
        host_addr = a;
        host_wdata = d;
        @(negedge core_clk);
        last_rd = host_rdata;
        cmd_select_n = 1'b1;
        chip_select_n = 1'b1;
        // Released bus shows no stale value
        host_addr = ~a;
        host_wdata = ~d;
    endtask
    // jump strobes high through load and next cycle
    // Returns in the cycle after capture; the caller ends the transfer
    task automatic seq_load(input logic [11:0] a, input logic adv_n);
        @(negedge core_clk);
        seq_port_select_n = 1'b0;
        seq_read_not_write = 1'b0;
        pointer_load_strobe_n = 1'b0;
        count_advance_enable_n = adv_n;
        seq_data_in = {4'he, a};
        @(negedge core_clk);
        pointer_load_strobe_n = 1'b1;
        seq_data_in = ~seq_data_in;
    endtask
    task automatic jump(input logic second);
        @(negedge core_clk);
        seq_port_select_n = 1'b0;
        jump_first_start_n = second;
        jump_second_start_n = !second;
        @(negedge core_clk);
        jump_first_start_n = 1'b1;
        jump_second_start_n = 1'b1;
        seq_port_select_n = 1'b1;
    endtask
    task automatic advance(input int n);
        @(negedge core_clk);
        seq_port_select_n = 1'b0;
        count_advance_enable_n = 1'b0;
        repeat (n) @(negedge core_clk);
        count_advance_enable_n = 1'b1;
        seq_port_select_n = 1'b1;
    endtask
endmodule

// >>> tb/seq_buffer_pointer_control_tb.sv
// Self-checking bench for the sequential buffer pointer control block
`timescale 1ns/1ps
module seq_buffer_pointer_control_tb;
    logic core_clk, rst, pointer_load_strobe_n, jump_first_start_n, jump_second_start_n;
    logic count_advance_enable_n, seq_port_select_n, seq_read_not_write, cmd_select_n;
    logic chip_select_n, host_read_not_write, seq_write_allowed, seq_select_reg_n;
    logic seq_rnw_reg, first_end_flag_n, second_end_flag_n;
    logic [15:0] seq_data_in, host_wdata, host_rdata;
    logic [11:0] host_addr, seq_pointer;
    int error_cnt = 0;
    int cmp_count = 0;
    sbpc_top dut_u (.*);
    sbpc_seq_host_model m_u (.*);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] exp, input string what);
        m_u.host_cycle(1'b1, 1'b1, a, 16'h0000);
        chk(what, exp, m_u.last_rd);
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        m_u.host_cycle(1'b0, 1'b1, a, d);
    endtask
    task automatic ptr(input string what, input logic [11:0] exp);
        chk(what, {4'h0, exp}, {4'h0, seq_pointer});
    endtask
    // Bounded wait; a flag that never drops ends the run
    task automatic wait_flag(input logic second);
        int i;
        i = 0;
        while (i < 4 && (second ? second_end_flag_n : first_end_flag_n) !== 1'b0) begin
            @(negedge core_clk);
            i++;
        end
        chk("end flag", 16'h0000, {15'h0, second ? second_end_flag_n : first_end_flag_n});
        if (i == 4) summarize();
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values();
        logic [15:0] tab [8];
        tab = '{16'he000, 16'hefff, 16'he000, 16'he000, 16'h0, 16'hfffc, 16'hffff, 16'hffff};
        ptr("reset pointer", 12'h000);
        chk("state regs", 16'h0002, {14'h0, seq_select_reg_n, seq_rnw_reg});
        chk("flags", 16'h0003, {14'h0, first_end_flag_n, second_end_flag_n});
        for (int c = 0; c < 8; c++) begin
            if (c != 4) rd(c[11:0], tab[c], "reset reg");
        end
        m_u.host_cycle(1'b1, 1'b1, 12'h004, 16'h0000);
        chk("flow reset", 16'h0000, {12'h0, m_u.last_rd[3:0]});
    endtask
    task automatic t_cmd_decode();
        logic [15:0] tab [4];
        tab = '{16'h000c, 16'h0010, 16'h0200, 16'h0203};
        wr(12'hff8, 16'hf123);
        rd(12'hff8, 16'he123, "alias write");
        m_u.host_cycle(1'b0, 1'b0, 12'h001, 16'h0456);
        rd(12'h001, 16'hefff, "deselected write");
        for (int c = 0; c < 4; c++) wr(c[11:0], tab[c]);
        for (int c = 0; c < 4; c++) rd(c[11:0], tab[c] | 16'he000, "readback");
        wr(12'h004, 16'h0000);
    endtask
    task automatic t_load();
        logic [11:0] p0;
        p0 = seq_pointer;
        m_u.seq_load(12'h123, 1'b0);
        ptr("load gap", p0);
        chk("write in load", 16'h0, {15'h0, seq_write_allowed});
        chk("seq regs", 16'h0000, {14'h0, seq_select_reg_n, seq_rnw_reg});
        @(negedge core_clk);
        ptr("loaded", 12'h123);
        @(negedge core_clk);
        m_u.count_advance_enable_n = 1'b1;
        m_u.seq_port_select_n = 1'b1;
        m_u.seq_read_not_write = 1'b1;
        ptr("post load advance", 12'h124);
    endtask
    task automatic t_jump();
        m_u.jump(1'b0);
        ptr("jump first", 12'h00c);
        m_u.jump(1'b1);
        ptr("jump second", 12'h200);
    endtask
    task automatic t_chain();
        logic [11:0] tab [5];
        tab = '{12'h00d, 12'h00e, 12'h00f, 12'h010, 12'h200};
        m_u.jump(1'b0);
        for (int i = 0; i < 5; i++) begin
            m_u.advance(1);
            ptr("chain step", tab[i]);
        end
        wait_flag(1'b0);
        rd(12'h005, 16'hfffd, "flag status");
        wr(12'h005, 16'hffff);
        rd(12'h005, 16'hfffd, "flag kept");
        wr(12'h005, 16'hfffe);
        rd(12'h005, 16'hfffc, "flag cleared");
        chk("flag out high", 16'h0001, {15'h0, first_end_flag_n});
    endtask
    task automatic t_stop();
        wr(12'h004, 16'h0004);
        m_u.host_cycle(1'b1, 1'b1, 12'h004, 16'h0000);
        chk("flow mode", 16'h0004, {12'h0, m_u.last_rd[3:0]});
        m_u.jump(1'b1);
        m_u.advance(6);
        ptr("halted", 12'h203);
        chk("write halted", 16'h0, {15'h0, seq_write_allowed});
        wait_flag(1'b1);
        wr(12'h004, 16'h0014);
        chk("held by bit4 one", 16'h0, {15'h0, seq_write_allowed});
        wr(12'h004, 16'h0004);
        chk("released", 16'h0001, {15'h0, seq_write_allowed});
    endtask
    task automatic t_async_reset();
        @(negedge core_clk);
        #2 rst = 1'b1;
        #1 ptr("async reset", 12'h000);
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        chk("flags again", 16'h0003, {14'h0, first_end_flag_n, second_end_flag_n});
        rd(12'h001, 16'hefff, "end after reset");
    endtask
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        t_reset_values();
        t_cmd_decode();
        t_load();
        t_jump();
        t_chain();
        t_stop();
        t_async_reset();
        summarize();
    end
    initial begin
        #200000;
        error_cnt++;
        $display("CHECK FAILED watchdog expected done seen hang");
        summarize();
    end
endmodule
